// File: shared/mdsf_pkg.sv
// Constants for the motion/drive status flag block.
// Assumes a single 10 MHz clock and a synchronous active-low reset.
// Functional notes
// - Homing-done flag high only after a successful homing; low otherwise.
// - Stopped flag high whenever motor not moving in command mode; immediate stop never sets motion-done.
// - Hold flag high once an active move was brought into hold.
// - Bit 1 shows counter-clockwise rotation, bit 0 clockwise rotation.
// - Output-stage-on bit high while driver enabled and no overtemperature, even when idle reduction removes current.
// - With driver enabled, emergency stop does not remove motor current.
// - Overheat or idle with zero-percent reduction removes motor current.
// - Stall bit set when a motor stall is detected.
// - Acknowledge set on preset/reset completion, cleared after host drops command bit.
// - Absolute encoder fault bit reflects encoder-reported damage conditions.
// - Heartbeat toggles about every 500 ms in command mode only.
// - Limit bit set on end limit during move; cleared on release or reset errors.
// - Invalid jog bit set on bad jog change; only valid jog data clears it.
// - Reserved bits 8, 5, 3 and 2 of drive word always read zero.
// - Overtemperature while enabled sets driver fault, removes current, clears itself.
// - Physical link loss sets link-lost bit and input fault when link returns.
// - Temperature warning bit set while processor exceeds 90 degrees C.
// - Bits 1 and 0 follow the configured active state of inputs b and a.
// - Bit 15 of motion word is one in configuration mode, zero in command mode.
package mdsf_pkg;
  localparam int CLK_HZ = 10000000;
  localparam int HEARTBEAT_MS = 500;
  localparam int HEARTBEAT_CYC = CLK_HZ / 1000 * HEARTBEAT_MS;
  // Motion word bits
  localparam int MW_CW = 0;
  localparam int MW_CCW = 1;
  localparam int MW_HOLD = 2;
  localparam int MW_STOPPED = 3;
  localparam int MW_HOME = 4;
  localparam int MW_MODE = 15;
  // Drive word bits
  localparam int DW_IN_A = 0;
  localparam int DW_IN_B = 1;
  localparam int DW_TEMP_WARN = 4;
  localparam int DW_LINK_LOST = 6;
  localparam int DW_DRV_FAULT = 7;
  localparam int DW_BAD_JOG = 9;
  localparam int DW_LIMIT = 10;
  localparam int DW_HEARTBEAT = 11;
  localparam int DW_ABS_ENC = 12;
  localparam int DW_CMD_ACK = 13;
  localparam int DW_STALL = 14;
  localparam int DW_STAGE_ON = 15;
  localparam logic [15:0] DW_RSVD_MASK = 16'h012C;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  typedef enum logic [2:0] {
    MDSF_ACK_IDLE = 3'h1,
    MDSF_ACK_SET = 3'h2,
    MDSF_ACK_WAIT = 3'h4
  } mdsf_ack_t;
endpackage

// File: sim/mdsf_host_model.sv
// Host controller model: raises the command bit and drops it after the acknowledge.
// Assumes the drive status word is read on every mclk rising edge.
`timescale 1ns/1ps
module mdsf_host_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Bench control
  input wire logic cmd_go,
  input wire logic may_drop,
  // Device side
  input wire logic [15:0] drive_status_word,
  output logic ack_cmd_bit
);
  // Holding off the drop lets the bench see the acknowledge stand
  always_ff @(posedge mclk) begin
    if (!rst_b) ack_cmd_bit <= 1'b0;
    else if (cmd_go) ack_cmd_bit <= 1'b1;
    else if (may_drop && drive_status_word[mdsf_pkg::DW_CMD_ACK]) ack_cmd_bit <= 1'b0;
  end
endmodule // mdsf_host_model

// File: sim/mdsf_status_tb.sv
// Self-checking bench for the status flag generator.
// Assumes a short heartbeat period and the host model for the command bit.
`timescale 1ns/1ps
module mdsf_status_tb;
  localparam int HB = 10;
  localparam int HBB = mdsf_pkg::DW_HEARTBEAT;
  localparam logic [15:0] NO_HB = 16'hF7FF;
  logic mclk = 1'b0;
  logic rst_b, config_mode, homing_ok, homing_start, move_start, motor_moving, dir_ccw, hold_reached;
  logic drive_enable, estop_in, overtemp, idle_zero_current, stall_seen, proc_temp_high, ack_cmd_done;
  logic ack_cmd_bit, reset_errors, jog_bad_change, jog_good_data, limit_hit_in_move, limit_active;
  logic enc_fault, phy_link_up, aux_input_a_on, aux_input_b_on, cmd_go, may_drop;
  logic [15:0] motion_status_word, drive_status_word;
  logic motor_current_on, input_fault_set;
  int n_errors = 0;
  int n_compared = 0;
  int cyc = 0;
  always #50 mclk = ~mclk;
  mdsf_status #(.HB_PERIOD(HB)) i_mdsf_status (.mclk, .rst_b, .config_mode, .homing_ok, .homing_start,
    .move_start, .motor_moving, .dir_ccw, .hold_reached, .drive_enable, .estop_in, .overtemp,
    .idle_zero_current, .stall_seen, .proc_temp_high, .ack_cmd_done, .ack_cmd_bit, .reset_errors,
    .jog_bad_change, .jog_good_data, .limit_hit_in_move, .limit_active, .enc_fault, .phy_link_up,
    .aux_input_a_on, .aux_input_b_on, .motion_status_word, .drive_status_word, .motor_current_on,
    .input_fault_set);
  mdsf_host_model i_mdsf_host_model (.mclk, .rst_b, .cmd_go, .may_drop, .drive_status_word, .ack_cmd_bit);
  function automatic logic [15:0] b1(input logic v);
    return {15'h0000, v};
  endfunction
  // Heartbeat masked: its phase is free
  function automatic logic [15:0] dw();
    return drive_status_word & NO_HB;
  endfunction
  task automatic wt(input int n);
    repeat (n) @(posedge mclk);
    @(negedge mclk);
  endtask
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_errors++;
      end_of_test();
    end
  end
  task automatic t_motion;
    chk("idle", 16'h0008, motion_status_word);
    @(posedge mclk) homing_ok <= 1'b1;
    @(posedge mclk) homing_ok <= 1'b0;
    wt(3);
    chk("homed", 16'h0018, motion_status_word);
    @(posedge mclk) homing_start <= 1'b1;
    @(posedge mclk);
    homing_start <= 1'b0;
    motor_moving <= 1'b1;
    dir_ccw <= 1'b1;
    wt(3);
    chk("ccw", 16'h0002, motion_status_word);
    @(posedge mclk) dir_ccw <= 1'b0;
    wt(2);
    chk("cw", 16'h0001, motion_status_word);
    @(posedge mclk);
    hold_reached <= 1'b1;
    motor_moving <= 1'b0;
    @(posedge mclk) hold_reached <= 1'b0;
    wt(3);
    chk("hold", 16'h000C, motion_status_word);
    @(posedge mclk) move_start <= 1'b1;
    @(posedge mclk) move_start <= 1'b0;
    wt(3);
    chk("hold gone", 16'h0008, motion_status_word);
    $display("test motion done");
  endtask
  task automatic t_drive;
    @(posedge mclk);
    drive_enable <= 1'b1;
    estop_in <= 1'b1;
    motor_moving <= 1'b1;
    wt(2);
    chk("stage on", 16'h8000, dw());
    chk("current estop", 16'h0001, b1(motor_current_on));
    @(posedge mclk) overtemp <= 1'b1;
    wt(2);
    chk("hot word", 16'h0080, dw());
    chk("hot current", 16'h0000, b1(motor_current_on));
    @(posedge mclk) overtemp <= 1'b0;
    wt(2);
    chk("fault cleared", 16'h8000, dw());
    @(posedge mclk);
    motor_moving <= 1'b0;
    idle_zero_current <= 1'b1;
    wt(2);
    chk("idle current", 16'h0000, b1(motor_current_on));
    @(posedge mclk);
    {drive_enable, estop_in, idle_zero_current} <= 3'h0;
    $display("test drive done");
  endtask
  task automatic t_ack;
    @(posedge mclk) cmd_go <= 1'b1;
    @(posedge mclk);
    cmd_go <= 1'b0;
    ack_cmd_done <= 1'b1;
    @(posedge mclk) ack_cmd_done <= 1'b0;
    wt(4);
    chk("ack held", 16'h2000, dw());
    @(posedge mclk) may_drop <= 1'b1;
    wt(4);
    chk("ack cleared", 16'h0000, dw());
    chk("cmd bit", 16'h0000, b1(ack_cmd_bit));
    $display("test ack done");
  endtask
  task automatic t_limit_jog;
    @(posedge mclk);
    {limit_active, limit_hit_in_move, jog_bad_change} <= 3'h7;
    @(posedge mclk) {limit_hit_in_move, jog_bad_change} <= 2'h0;
    wt(3);
    chk("limit jog", 16'h0600, dw());
    @(posedge mclk) limit_active <= 1'b0;
    wt(3);
    chk("limit released", 16'h0200, dw());
    @(posedge mclk) {limit_active, limit_hit_in_move} <= 2'h3;
    @(posedge mclk) {limit_hit_in_move, reset_errors} <= 2'h1;
    @(posedge mclk) reset_errors <= 1'b0;
    wt(3);
    chk("reset errors", 16'h0200, dw());
    @(posedge mclk) {limit_active, jog_good_data} <= 2'h1;
    @(posedge mclk) jog_good_data <= 1'b0;
    wt(3);
    chk("jog good", 16'h0000, dw());
    $display("test limit jog done");
  endtask
  task automatic t_link_flags;
    int pulses;
    pulses = 0;
    @(posedge mclk) phy_link_up <= 1'b0;
    wt(3);
    chk("link down", 16'h0000, dw());
    @(posedge mclk) phy_link_up <= 1'b1;
    repeat (6) begin
      @(negedge mclk);
      if (input_fault_set === 1'b1) pulses++;
    end
    chk("input fault pulses", 16'h0001, pulses[15:0]);
    chk("link lost", 16'h0040, dw());
    @(posedge mclk);
    {stall_seen, enc_fault, proc_temp_high, aux_input_a_on, aux_input_b_on} <= 5'h1F;
    wt(3);
    chk("flags", 16'h5053, dw());
    @(posedge mclk) reset_errors <= 1'b1;
    @(posedge mclk) reset_errors <= 1'b0;
    wt(3);
    chk("link lost cleared", 16'h5013, dw());
    $display("test link flags done");
  endtask
  task automatic t_beat;
    int flips;
    logic last;
    flips = 0;
    last = drive_status_word[HBB];
    repeat (10 * HB) begin
      @(negedge mclk);
      if (drive_status_word[HBB] !== last) flips++;
      last = drive_status_word[HBB];
    end
    chk("beat flips", 16'h000A, flips[15:0]);
    @(posedge mclk) config_mode <= 1'b1;
    wt(3);
    chk("config word", 16'h8000, motion_status_word);
    chk("config beat", 16'h0000, b1(drive_status_word[HBB]));
    $display("test beat done");
  endtask
  initial begin
    {config_mode, homing_ok, homing_start, move_start, motor_moving, dir_ccw, hold_reached, drive_enable,
      estop_in, overtemp, idle_zero_current, stall_seen, proc_temp_high, ack_cmd_done, reset_errors,
      jog_bad_change, jog_good_data, limit_hit_in_move, limit_active, enc_fault, aux_input_a_on,
      aux_input_b_on, cmd_go, may_drop, rst_b} <= 25'h0;
    phy_link_up <= 1'b1;
    wt(5);
    chk("reset words", 16'h0000, motion_status_word | drive_status_word);
    @(posedge mclk) rst_b <= 1'b1;
    wt(2);
    t_motion();
    t_drive();
    t_ack();
    t_limit_jog();
    t_link_flags();
    t_beat();
    end_of_test();
  end
endmodule // mdsf_status_tb

// File: verilog/mdsf_heartbeat.sv
// Heartbeat divider: toggles a level every PERIOD cycles while enabled.
// Assumes one clock; counter restarts whenever disabled.
`timescale 1ns/1ps
module mdsf_heartbeat #(
  parameter int PERIOD = mdsf_pkg::HEARTBEAT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Control and output
  input wire logic run,
  output logic beat
);
  initial begin
    if (PERIOD < 2) $error("PERIOD must be at least 2");
  end
  logic [31:0] cnt_r, cnt_nxt;
  logic beat_r, beat_nxt;
  always_comb begin
    cnt_nxt = cnt_r;
    beat_nxt = beat_r;
    if (!run) begin
      cnt_nxt = 32'h00000000;
      beat_nxt = 1'b0;
    end else if (cnt_r == 32'(PERIOD - 1)) begin
      cnt_nxt = 32'h00000000;
      beat_nxt = ~beat_r;
    end else begin
      cnt_nxt = cnt_r + 32'h00000001;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      cnt_r <= 32'h00000000;
      beat_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      beat_r <= beat_nxt;
    end
  end
  assign beat = beat_r;
endmodule // mdsf_heartbeat

// File: verilog/mdsf_status.sv
// Status flag generator: builds the motion and drive status words.
// Assumes motion, driver and input conditions come from synchronous logic.
`timescale 1ns/1ps
module mdsf_status #(
  parameter int HB_PERIOD = mdsf_pkg::HEARTBEAT_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Mode
  input wire logic config_mode,
  // Motion conditions
  input wire logic homing_ok,
  input wire logic homing_start,
  input wire logic move_start,
  input wire logic motor_moving,
  input wire logic dir_ccw,
  input wire logic hold_reached,
  // Driver conditions
  input wire logic drive_enable,
  input wire logic estop_in,
  input wire logic overtemp,
  input wire logic idle_zero_current,
  input wire logic stall_seen,
  input wire logic proc_temp_high,
  // Commands
  input wire logic ack_cmd_done,
  input wire logic ack_cmd_bit,
  input wire logic reset_errors,
  input wire logic jog_bad_change,
  input wire logic jog_good_data,
  input wire logic limit_hit_in_move,
  input wire logic limit_active,
  // Encoder and link
  input wire logic enc_fault,
  input wire logic phy_link_up,
  // Inputs, already polarity-corrected
  input wire logic aux_input_a_on,
  input wire logic aux_input_b_on,
  // Outputs
  output logic [15:0] motion_status_word,
  output logic [15:0] drive_status_word,
  output logic motor_current_on,
  output logic input_fault_set
);
  logic homing_done_r, homing_done_nxt;
  logic hold_r, hold_nxt;
  logic limit_r, limit_nxt;
  logic limit_prev_r, limit_prev_nxt;
  logic bad_jog_r, bad_jog_nxt;
  logic link_prev_r, link_prev_nxt;
  logic link_lost_r, link_lost_nxt;
  logic link_down_r, link_down_nxt;
  logic relink_r, relink_nxt;
  mdsf_pkg::mdsf_ack_t ack_r, ack_nxt;
  logic [15:0] mw_r, mw_nxt, dw_r, dw_nxt;
  logic cur_r, cur_nxt;
  logic beat;

  mdsf_heartbeat #(.PERIOD(HB_PERIOD)) u_hb (
    .mclk(mclk),
    .rst_b(rst_b),
    .run(!config_mode),
    .beat(beat)
  );

  // Sticky flags; a set in the same cycle as its clear wins
  always_comb begin
    homing_done_nxt = homing_done_r;
    if (homing_start || move_start) homing_done_nxt = 1'b0;
    if (homing_ok) homing_done_nxt = 1'b1;
    hold_nxt = hold_r;
    if (move_start || !motor_moving && !hold_r) hold_nxt = 1'b0;
    if (move_start) hold_nxt = 1'b0;
    if (hold_reached) hold_nxt = 1'b1;
    limit_prev_nxt = limit_active;
    limit_nxt = limit_r;
    if (reset_errors || (limit_prev_r && !limit_active)) limit_nxt = 1'b0;
    if (limit_hit_in_move) limit_nxt = 1'b1;
    bad_jog_nxt = bad_jog_r;
    if (jog_good_data) bad_jog_nxt = 1'b0;
    if (jog_bad_change) bad_jog_nxt = 1'b1;
    link_prev_nxt = phy_link_up;
    link_down_nxt = link_down_r;
    if (link_prev_r && !phy_link_up) link_down_nxt = 1'b1;
    relink_nxt = 1'b0;
    link_lost_nxt = link_lost_r;
    if (reset_errors) link_lost_nxt = 1'b0;
    if (link_down_r && phy_link_up) begin
      link_down_nxt = 1'b0;
      link_lost_nxt = 1'b1;
      relink_nxt = 1'b1;
    end
  end

  // Command acknowledge handshake
  always_comb begin
    case (ack_r)
      mdsf_pkg::MDSF_ACK_IDLE: ack_nxt = ack_cmd_done ? mdsf_pkg::MDSF_ACK_SET : mdsf_pkg::MDSF_ACK_IDLE;
      mdsf_pkg::MDSF_ACK_SET: ack_nxt = ack_cmd_bit ? mdsf_pkg::MDSF_ACK_SET : mdsf_pkg::MDSF_ACK_IDLE;
      mdsf_pkg::MDSF_ACK_WAIT: ack_nxt = mdsf_pkg::MDSF_ACK_IDLE;
      default: ack_nxt = mdsf_pkg::MDSF_ACK_IDLE;
    endcase
  end

  // Current gating and word assembly
  always_comb begin
    // Estop deliberately ignored while the stage is enabled
    cur_nxt = drive_enable && !overtemp && !(!motor_moving && idle_zero_current);
    mw_nxt = mdsf_pkg::WORD_RESET;
    mw_nxt[mdsf_pkg::MW_MODE] = config_mode;
    if (!config_mode) begin
      mw_nxt[mdsf_pkg::MW_HOME] = homing_done_r;
      mw_nxt[mdsf_pkg::MW_STOPPED] = !motor_moving;
      mw_nxt[mdsf_pkg::MW_HOLD] = hold_r;
      mw_nxt[mdsf_pkg::MW_CCW] = motor_moving && dir_ccw;
      mw_nxt[mdsf_pkg::MW_CW] = motor_moving && !dir_ccw;
    end
    dw_nxt = mdsf_pkg::WORD_RESET;
    dw_nxt[mdsf_pkg::DW_STAGE_ON] = drive_enable && !overtemp;
    dw_nxt[mdsf_pkg::DW_STALL] = stall_seen;
    dw_nxt[mdsf_pkg::DW_CMD_ACK] = (ack_r == mdsf_pkg::MDSF_ACK_SET);
    dw_nxt[mdsf_pkg::DW_ABS_ENC] = enc_fault;
    dw_nxt[mdsf_pkg::DW_HEARTBEAT] = !config_mode && beat;
    dw_nxt[mdsf_pkg::DW_LIMIT] = limit_r;
    dw_nxt[mdsf_pkg::DW_BAD_JOG] = bad_jog_r;
    dw_nxt[mdsf_pkg::DW_DRV_FAULT] = drive_enable && overtemp;
    dw_nxt[mdsf_pkg::DW_LINK_LOST] = link_lost_r;
    dw_nxt[mdsf_pkg::DW_TEMP_WARN] = proc_temp_high;
    dw_nxt[mdsf_pkg::DW_IN_B] = aux_input_b_on;
    dw_nxt[mdsf_pkg::DW_IN_A] = aux_input_a_on;
    dw_nxt = dw_nxt & ~mdsf_pkg::DW_RSVD_MASK;
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      homing_done_r <= 1'b0;
      hold_r <= 1'b0;
      limit_r <= 1'b0;
      limit_prev_r <= 1'b0;
      bad_jog_r <= 1'b0;
      link_prev_r <= 1'b0;
      link_down_r <= 1'b0;
      link_lost_r <= 1'b0;
      relink_r <= 1'b0;
      ack_r <= mdsf_pkg::MDSF_ACK_IDLE;
      mw_r <= mdsf_pkg::WORD_RESET;
      dw_r <= mdsf_pkg::WORD_RESET;
      cur_r <= 1'b0;
    end else begin
      homing_done_r <= homing_done_nxt;
      hold_r <= hold_nxt;
      limit_r <= limit_nxt;
      limit_prev_r <= limit_prev_nxt;
      bad_jog_r <= bad_jog_nxt;
      link_prev_r <= link_prev_nxt;
      link_down_r <= link_down_nxt;
      link_lost_r <= link_lost_nxt;
      relink_r <= relink_nxt;
      ack_r <= ack_nxt;
      mw_r <= mw_nxt;
      dw_r <= dw_nxt;
      cur_r <= cur_nxt;
    end
  end

  assign motion_status_word = mw_r;
  assign drive_status_word = dw_r;
  assign motor_current_on = cur_r;
  assign input_fault_set = relink_r;

  // Checks
  // Relink is seen once a lost physical link comes back
  sequence s_relink;
    link_down_r && phy_link_up;
  endsequence
  sequence s_relink_report;
    input_fault_set ##1 drive_status_word[6];
  endsequence
  a_home_flag_set: assert property (@(posedge mclk) disable iff (!rst_b)
    homing_ok && !config_mode |=> ##1 motion_status_word[4]) else $error("homing flag missing");
  a_stopped_flag: assert property (@(posedge mclk) disable iff (!rst_b)
    !motor_moving && !config_mode |=> motion_status_word[3]) else $error("stopped flag missing");
  a_dir_exclusive: assert property (@(posedge mclk) disable iff (!rst_b)
    !(motion_status_word[1] && motion_status_word[0])) else $error("both directions set");
  a_current_overtemp: assert property (@(posedge mclk) disable iff (!rst_b)
    overtemp |=> !motor_current_on && drive_status_word[15] == 1'b0) else $error("current during fault");
  a_estop_current: assert property (@(posedge mclk) disable iff (!rst_b)
    estop_in && drive_enable && !overtemp && motor_moving |=> motor_current_on) else $error("estop cut current");
  a_ack_hold: assert property (@(posedge mclk) disable iff (!rst_b)
    drive_status_word[13] && ack_cmd_bit |=> ##1 drive_status_word[13]) else $error("ack dropped early");
  a_reserved_zero: assert property (@(posedge mclk) disable iff (!rst_b)
    (drive_status_word & 16'h012C) == 16'h0000) else $error("reserved bit set");
  a_jog_sticky: assert property (@(posedge mclk) disable iff (!rst_b)
    bad_jog_r && !jog_good_data |=> bad_jog_r) else $error("jog flag lost");
  a_limit_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    reset_errors && !limit_hit_in_move |=> ##1 !drive_status_word[10]) else $error("limit not cleared");
  a_relink_flag: assert property (@(posedge mclk) disable iff (!rst_b)
    s_relink |=> s_relink_report) else $error("relink not flagged");
  a_fault_pulse_once: assert property (@(posedge mclk) disable iff (!rst_b)
    input_fault_set |=> !input_fault_set) else $error("input fault pulse too long");
  a_home_flag_clear: assert property (@(posedge mclk) disable iff (!rst_b)
    (homing_start || move_start) && !homing_ok |=> ##1 !motion_status_word[4]) else $error("homing flag kept");
  a_hold_flag_set: assert property (@(posedge mclk) disable iff (!rst_b)
    hold_reached && !config_mode |=> ##1 motion_status_word[2]) else $error("hold flag missing");
  a_stage_on_bit: assert property (@(posedge mclk) disable iff (!rst_b)
    drive_enable && !overtemp |=> drive_status_word[15]) else $error("stage on bit missing");
  a_stall_bit: assert property (@(posedge mclk) disable iff (!rst_b)
    stall_seen |=> drive_status_word[14]) else $error("stall bit missing");
  a_ack_flag_set: assert property (@(posedge mclk) disable iff (!rst_b)
    ack_cmd_done && ack_r == mdsf_pkg::MDSF_ACK_IDLE |=> ##1 drive_status_word[13]) else $error("ack missing");
  a_enc_fault_bit: assert property (@(posedge mclk) disable iff (!rst_b)
    enc_fault |=> drive_status_word[12]) else $error("encoder fault bit missing");
  a_drv_fault_bit: assert property (@(posedge mclk) disable iff (!rst_b)
    drive_enable && overtemp |=> drive_status_word[7]) else $error("driver fault bit missing");
  a_temp_warn_bit: assert property (@(posedge mclk) disable iff (!rst_b)
    proc_temp_high |=> drive_status_word[4]) else $error("temperature bit missing");
  a_input_a_bit: assert property (@(posedge mclk) disable iff (!rst_b)
    aux_input_a_on |=> drive_status_word[0]) else $error("input a bit missing");
  a_input_b_bit: assert property (@(posedge mclk) disable iff (!rst_b)
    aux_input_b_on |=> drive_status_word[1]) else $error("input b bit missing");
  a_mode_bit: assert property (@(posedge mclk) disable iff (!rst_b)
    config_mode |=> motion_status_word[15] && !drive_status_word[11]) else $error("mode bit wrong");
endmodule // mdsf_status
